/* core/dicr_regs.sv */
// Purpose: parity/alarm and input mode configuration registers
// Assumes: single clock, synchronous active-low reset, read data one cycle after strobe
// Notes: unmapped indices read zero; writes to them are dropped
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dicr_regs (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [7:0]       addr,
    input  wire logic [15:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic      [15:0]      rdata,
    output dicr_pkg::dicr_cfg_s   cfg
);
    logic [15:0] parity_alarm_control;
    logic [15:0] input_mode_control;

    // reserved bits outside the masks stay at reset value; bit 8 writable so software can clear it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            parity_alarm_control <= dicr_pkg::PARITY_ALARM_RESET;
        end else if (wr && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX) begin
            parity_alarm_control <= wdata & dicr_pkg::PARITY_ALARM_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            input_mode_control <= dicr_pkg::INPUT_MODE_RESET;
        end else if (wr && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX) begin
            input_mode_control <= wdata & dicr_pkg::INPUT_MODE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= 16'h0000;
        end else if (rd && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX) begin
            rdata <= parity_alarm_control;
        end else if (rd && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX) begin
            rdata <= input_mode_control;
        end else begin
            rdata <= 16'h0000;
        end
    end

    // one flop per field so datapath consumers see a flop, one cycle after the register
    logic odd_parity;
    logic sync_parity_source;
    logic inphase_invert;
    logic quadrature_invert;
    logic two_apart_alarm_enable;
    logic one_apart_alarm_enable;
    logic collision_alarm_enable;
    logic word_wide_select;
    logic conv_clk_gone_shutdown;
    logic data_clk_gone_shutdown;
    logic collision_shutdown;
    logic four_wire_port_select;
    logic mixer_enable;
    logic mixer_gain_6db;
    logic oscillator_enable;
    logic bus_reverse;
    logic twos_complement;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            odd_parity <= 1'b0;
        end else begin
            odd_parity <= parity_alarm_control[dicr_pkg::PAR_ODD_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync_parity_source <= 1'b0;
        end else begin
            sync_parity_source <= parity_alarm_control[dicr_pkg::PAR_SYNC_SRC_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            inphase_invert <= 1'b0;
        end else begin
            inphase_invert <= parity_alarm_control[dicr_pkg::INPHASE_INV_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            quadrature_invert <= 1'b0;
        end else begin
            quadrature_invert <= parity_alarm_control[dicr_pkg::QUAD_INV_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            two_apart_alarm_enable <= 1'b0;
        end else begin
            two_apart_alarm_enable <= parity_alarm_control[dicr_pkg::TWO_APART_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            one_apart_alarm_enable <= 1'b0;
        end else begin
            one_apart_alarm_enable <= parity_alarm_control[dicr_pkg::ONE_APART_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            collision_alarm_enable <= 1'b0;
        end else begin
            collision_alarm_enable <= parity_alarm_control[dicr_pkg::COLLIDE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            word_wide_select <= 1'b0;
        end else begin
            word_wide_select <= input_mode_control[dicr_pkg::WORD_WIDE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            conv_clk_gone_shutdown <= 1'b0;
        end else begin
            conv_clk_gone_shutdown <= input_mode_control[dicr_pkg::CONV_CLK_GONE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_clk_gone_shutdown <= 1'b0;
        end else begin
            data_clk_gone_shutdown <= input_mode_control[dicr_pkg::DATA_CLK_GONE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            collision_shutdown <= 1'b0;
        end else begin
            collision_shutdown <= input_mode_control[dicr_pkg::COLLIDE_GONE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            four_wire_port_select <= 1'b0;
        end else begin
            four_wire_port_select <= input_mode_control[dicr_pkg::FOUR_WIRE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mixer_enable <= 1'b0;
        end else begin
            mixer_enable <= input_mode_control[dicr_pkg::MIXER_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mixer_gain_6db <= 1'b0;
        end else begin
            mixer_gain_6db <= input_mode_control[dicr_pkg::MIXER_GAIN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            oscillator_enable <= 1'b0;
        end else begin
            oscillator_enable <= input_mode_control[dicr_pkg::OSC_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_reverse <= 1'b0;
        end else begin
            bus_reverse <= input_mode_control[dicr_pkg::REV_BUS_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            twos_complement <= 1'b0;
        end else begin
            twos_complement <= input_mode_control[dicr_pkg::TWOS_BIT];
        end
    end

    // packing only: every field is still a flop output
    assign cfg = '{odd_parity, sync_parity_source, inphase_invert, quadrature_invert,
                   two_apart_alarm_enable, one_apart_alarm_enable, collision_alarm_enable,
                   word_wide_select, conv_clk_gone_shutdown, data_clk_gone_shutdown, collision_shutdown,
                   four_wire_port_select, mixer_enable, mixer_gain_6db, oscillator_enable,
                   bus_reverse, twos_complement};

    // strobes qualified by index, shared by the checks below
    logic wr_parity;
    logic wr_mode;
    logic rd_parity;
    logic rd_mode;
    always_comb begin
        wr_parity = wr && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX;
        wr_mode   = wr && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX;
        rd_parity = rd && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX;
        rd_mode   = rd && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX;
    end

    sequence s_parity_write;
        wr_parity;
    endsequence
    sequence s_mode_write;
        wr_mode;
    endsequence
    sequence s_quiet;
        !wr_parity && !wr_mode;
    endsequence
    sequence s_reset_release;
        !resetn ##1 resetn;
    endsequence

    a_four_wire_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.four_wire_port_select == $past(wdata[dicr_pkg::FOUR_WIRE_BIT], 2))
        else $error("four-wire select not taken from write");

    a_gain_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.mixer_gain_6db == $past(wdata[dicr_pkg::MIXER_GAIN_BIT], 2))
        else $error("mixer gain not taken from write");

    a_osc_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.oscillator_enable == $past(wdata[dicr_pkg::OSC_BIT], 2))
        else $error("oscillator enable not taken from write");

    a_bus_rev_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.bus_reverse == $past(wdata[dicr_pkg::REV_BUS_BIT], 2))
        else $error("bus reversal not taken from write");

    a_twos_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.twos_complement == $past(wdata[dicr_pkg::TWOS_BIT], 2))
        else $error("number format not taken from write");

    a_data_clk_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.data_clk_gone_shutdown == $past(wdata[dicr_pkg::DATA_CLK_GONE_BIT], 2))
        else $error("data clock shutdown not taken from write");

    a_collide_shut: assert property (@(posedge clk) disable iff (!resetn)
        s_mode_write |=> ##1
        cfg.collision_shutdown == $past(wdata[dicr_pkg::COLLIDE_GONE_BIT], 2))
        else $error("collision shutdown not taken from write");

    a_odd_parity_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_parity_write |=> ##1
        cfg.odd_parity == $past(wdata[dicr_pkg::PAR_ODD_BIT], 2))
        else $error("parity polarity not taken from write");

    a_one_apart_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_parity_write |=> ##1
        cfg.one_apart_alarm_enable == $past(wdata[dicr_pkg::ONE_APART_BIT], 2))
        else $error("one-apart alarm enable not taken from write");

    a_collide_en_follow: assert property (@(posedge clk) disable iff (!resetn)
        s_parity_write |=> ##1
        cfg.collision_alarm_enable == $past(wdata[dicr_pkg::COLLIDE_BIT], 2))
        else $error("collision alarm enable not taken from write");

    a_parity_readback: assert property (@(posedge clk) disable iff (!resetn)
        rd_parity |=>
        rdata == $past(parity_alarm_control))
        else $error("parity word read back wrong");

    a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!resetn)
        !rd_parity && !rd_mode |=>
        rdata == 16'h0000)
        else $error("read data not zero outside a mapped read");

    a_unmapped_drop: assert property (@(posedge clk) disable iff (!resetn)
        wr && !wr_parity && !wr_mode |=>
        $stable(parity_alarm_control) && $stable(input_mode_control))
        else $error("unmapped write changed a register");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        (parity_alarm_control & ~dicr_pkg::PARITY_ALARM_MASK) == 16'h0000
        && (input_mode_control & ~dicr_pkg::INPUT_MODE_MASK) == 16'h0000)
        else $error("reserved bit set in a register");

    a_reset_values: assert property (@(posedge clk)
        !resetn |=> parity_alarm_control == dicr_pkg::PARITY_ALARM_RESET
        && input_mode_control == dicr_pkg::INPUT_MODE_RESET)
        else $error("register reset value wrong");

    a_shutdown_reset: assert property (@(posedge clk)
        s_reset_release |=>
        {cfg.conv_clk_gone_shutdown, cfg.data_clk_gone_shutdown, cfg.collision_shutdown} == 3'h7)
        else $error("shutdown enables not set after reset");

    a_alarm_en_reset: assert property (@(posedge clk)
        s_reset_release |=>
        {cfg.two_apart_alarm_enable, cfg.one_apart_alarm_enable, cfg.collision_alarm_enable} == 3'h7)
        else $error("alarm enables not set after reset");

    a_cfg_holds: assert property (@(posedge clk) disable iff (!resetn)
        s_quiet |=> ##1
        $stable(cfg))
        else $error("configuration moved without a write");

    a_mode_write_lands: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX |=> ##1
        cfg.word_wide_select == $past(wdata[dicr_pkg::WORD_WIDE_BIT], 2))
        else $error("word width select not taken from write");
    a_mixer_follow: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX |=> ##1
        cfg.mixer_enable == $past(wdata[dicr_pkg::MIXER_BIT], 2))
        else $error("mixer enable not taken from write");
    a_inphase_invert: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX |=> ##1
        cfg.inphase_invert == $past(wdata[dicr_pkg::INPHASE_INV_BIT], 2))
        else $error("in-phase invert not taken from write");
    a_quad_invert: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX |=> ##1
        cfg.quadrature_invert == $past(wdata[dicr_pkg::QUAD_INV_BIT], 2))
        else $error("quadrature invert not taken from write");
    a_alarm_en_follow: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX |=> ##1
        {cfg.two_apart_alarm_enable, cfg.one_apart_alarm_enable, cfg.collision_alarm_enable}
        == $past(wdata[3:1], 2))
        else $error("alarm enables not taken from write");
    a_shutdown_follow: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX |=> ##1
        {cfg.conv_clk_gone_shutdown, cfg.data_clk_gone_shutdown, cfg.collision_shutdown}
        == $past(wdata[14:12], 2))
        else $error("shutdown enables not taken from write");
    a_parity_src: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == dicr_pkg::PARITY_ALARM_CONTROL_IDX |=> ##1
        cfg.sync_parity_source == $past(wdata[dicr_pkg::PAR_SYNC_SRC_BIT], 2)
        && cfg.odd_parity == $past(wdata[dicr_pkg::PAR_ODD_BIT], 2))
        else $error("parity controls not taken from write");
    a_mode_readback: assert property (@(posedge clk) disable iff (!resetn)
        rd && addr == dicr_pkg::INPUT_MODE_CONTROL_IDX && !$past(wr) |=>
        rdata == $past(input_mode_control))
        else $error("mode word read back wrong");
endmodule
`default_nettype wire

/* include/dicr_pkg.sv */
// Purpose: constants and carriers for the input configuration registers
// Assumes: 16-bit registers on a plain strobe port, index addressing
// Notes:
// Notes on behaviour
// - bit 9 of parity word makes the word sync strobe the parity source.
// - bit 6 complements in-phase channel data, like swapping its line polarity.
// - bit 5 complements quadrature channel data, like swapping its line polarity.
// - bit 3 enables the pointers-two-apart buffer alarm; resets to one.
// - bit 2 enables the pointers-one-apart buffer alarm; resets to one.
// - bit 1 enables the pointer collision buffer alarm; resets to one.
// - mode bit 15 selects word-wide input when set, byte-wide when clear; resets byte-wide.
// - mode bit 14 lets conversion clock loss shut the outputs off.
// - mode bit 13 lets input data clock loss shut the outputs off.
// - mode bit 12 lets pointer collision alarms shut the outputs off.
// - mode bit 7 selects four-wire serial port when set, three-wire when clear.
// - mode bit 6 enables the complex mixer.
// - mode bit 5 adds 6dB gain to the mixer output.
// - mode bit 4 enables the oscillator; coarse mixing does not need it.
// - bus reversal bit reverses input bus bit order, msb becomes lsb.
// - mode bit 1 selects two's complement input when set, offset binary when clear.
// - parity polarity bit selects even parity at zero, odd at one.
package dicr_pkg;
    localparam logic [7:0]  PARITY_ALARM_CONTROL_IDX = 8'h01;
    localparam logic [7:0]  INPUT_MODE_CONTROL_IDX   = 8'h02;
    // parity word bits 11, 9, 8, 6, 5, 3, 2 and 1 are held here; the other bits read zero
    localparam logic [15:0] PARITY_ALARM_RESET       = 16'h010e;
    localparam logic [15:0] PARITY_ALARM_MASK        = 16'h0b6e;
    localparam logic [15:0] INPUT_MODE_RESET         = 16'h7000;
    localparam logic [15:0] INPUT_MODE_MASK          = 16'hf0fa;
    localparam int PAR_ODD_BIT       = 11;
    localparam int PAR_SYNC_SRC_BIT  = 9;
    localparam int PAR_RSVD_BIT      = 8;
    localparam int INPHASE_INV_BIT   = 6;
    localparam int QUAD_INV_BIT      = 5;
    localparam int TWO_APART_BIT     = 3;
    localparam int ONE_APART_BIT     = 2;
    localparam int COLLIDE_BIT       = 1;
    localparam int WORD_WIDE_BIT     = 15;
    localparam int CONV_CLK_GONE_BIT = 14;
    localparam int DATA_CLK_GONE_BIT = 13;
    localparam int COLLIDE_GONE_BIT  = 12;
    localparam int FOUR_WIRE_BIT     = 7;
    localparam int MIXER_BIT         = 6;
    localparam int MIXER_GAIN_BIT    = 5;
    localparam int OSC_BIT           = 4;
    localparam int REV_BUS_BIT       = 3;
    localparam int TWOS_BIT          = 1;

    typedef struct packed {
        logic odd_parity;
        logic sync_parity_source;
        logic inphase_invert;
        logic quadrature_invert;
        logic two_apart_alarm_enable;
        logic one_apart_alarm_enable;
        logic collision_alarm_enable;
        logic word_wide_select;
        logic conv_clk_gone_shutdown;
        logic data_clk_gone_shutdown;
        logic collision_shutdown;
        logic four_wire_port_select;
        logic mixer_enable;
        logic mixer_gain_6db;
        logic oscillator_enable;
        logic bus_reverse;
        logic twos_complement;
    } dicr_cfg_s;
endpackage

/* test/dicr_regs_tb.sv */
// Purpose: self-checking bench for the input configuration registers
// Assumes: read data one cycle after the read strobe, cfg one cycle after the register
// Notes: the write strobe is left up between calls so accesses run back to back; reads drop theirs
`timescale 1ns/10ps
`default_nettype none
module dicr_regs_tb;
    logic                clk;
    logic                resetn;
    logic [7:0]          addr;
    logic [15:0]         wdata;
    logic                wr;
    logic                rd;
    logic [15:0]         rdata;
    dicr_pkg::dicr_cfg_s cfg;
    int                  err_count;
    int                  checked;
    logic [15:0]         v;
    logic [15:0]         pats [5] = '{16'hffff, 16'h0000, 16'ha5a5, 16'h5a5a, 16'h0208};

    dicr_regs uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                   .rdata(rdata), .cfg(cfg));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write is left standing; the next call's edge takes it
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1; wr <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // field order follows the struct; built from bit positions, not the design
    function automatic dicr_pkg::dicr_cfg_s exp_cfg(input logic [15:0] p, input logic [15:0] m);
        exp_cfg = '{p[11], p[9], p[6], p[5], p[3], p[2], p[1], m[15], m[14], m[13], m[12],
                    m[7], m[6], m[5], m[4], m[3], m[1]};
    endfunction

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // cut a hang short
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        resetn = 1'b0; addr = 8'h00; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
        err_count = 0; checked = 0;
        repeat (5) @(posedge clk);
        #1 chk("cfg in reset", 17'h00000, cfg);
        @(posedge clk) resetn <= 1'b1;
        rd_reg(8'h01, v); chk("parity reset", {1'b0, 16'h010e}, {1'b0, v});
        rd_reg(8'h02, v); chk("mode reset", {1'b0, 16'h7000}, {1'b0, v});
        chk("cfg reset", exp_cfg(16'h010e, 16'h7000), cfg);
        @(posedge clk);
        #1 chk("rdata idle", 17'h00000, {1'b0, rdata});
        $display("test reset done");
        foreach (pats[i]) begin
            wr_reg(8'h01, pats[i]);
            wr_reg(8'h02, ~pats[i]);
            rd_reg(8'h01, v); chk("parity rw", {1'b0, pats[i] & 16'h0b6e}, {1'b0, v});
            rd_reg(8'h02, v); chk("mode rw", {1'b0, ~pats[i] & 16'hf0fa}, {1'b0, v});
            chk("cfg fields", exp_cfg(pats[i] & 16'h0b6e, ~pats[i] & 16'hf0fa), cfg);
        end
        $display("test patterns done");
        wr_reg(8'h03, 16'hffff);
        wr_reg(8'h00, 16'hffff);
        rd_reg(8'h03, v); chk("unmapped read", 17'h00000, {1'b0, v});
        rd_reg(8'h01, v); chk("parity kept", {1'b0, 16'h0208}, {1'b0, v});
        rd_reg(8'h02, v); chk("mode kept", {1'b0, 16'hf0f2}, {1'b0, v});
        $display("test unmapped done");
        print_verdict();
    end
endmodule
`default_nettype wire
